/* File: halfband_fir_decimator.sv */
// half-band decimate-by-two, optional 66-tap fir and optional fs/8 final oscillator
// assumes input samples, config bits and the write strobe share ref_clk; syncPin is asynchronous
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - half-band emits one sample per two inputs
// - 19-tap symmetric polyphase, only nonzero taps computed
// - fixed 20-bit half-band coefficients, odd taps other than the centre tap zero
// - half-band always in path, never bypassed
// - config bit selects high-pass or low-pass
// - config bit spectrally reverses half-band output
// - decimation phase picks first or second sample
// - 66-tap symmetric fir, 21-bit constant coefficients
// - fir does not decimate further
// - fir coefficients take the tabulated values
// - fir enable bit inserts or bypasses fir
// - sync every pulse or first after write
// - accepted sync restarts decimation at programmed phase
// - i and q filtered identically
// - final oscillator shifts up fs/8, real output
// - bypassed oscillator interleaves i then q when the tuning oscillator is on, else i only
// - tuning oscillator off feeds real converter samples
module halfband_fir_decimator #(
    parameter int DW = 16
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic signed [DW-1:0] adcData,
    input wire logic signed [DW-1:0] tuneI,
    input wire logic signed [DW-1:0] tuneQ,
    input wire logic inValid,
    input wire logic syncPin,
    input wire logic hbHighPass,
    input wire logic hbSpecRev,
    input wire logic hbDecPhase,
    input wire logic firEnable,
    input wire logic syncEnable,
    input wire logic syncFirstOnly,
    input wire logic syncCfgWrite,
    input wire logic tuneOscEnable,
    input wire logic finalOscEnable,
    output logic signed [DW-1:0] outData,
    output logic outValid,
    output logic outIsQ
);
    // =========================================
    // elaboration checks
    if (DW < halfband_fir_pkg::DW_MIN || DW > halfband_fir_pkg::DW_MAX) begin : g_badWidth
        $error("data width outside supported range");
    end

    // =========================================
    // coefficient and oscillator tables
    // half-band tap k; high-pass flips the sign of taps an odd distance from centre
    function automatic logic signed [19:0] hbCoef(input int k, input logic hp);
        logic signed [19:0] c;
        int d;
        d = (k < halfband_fir_pkg::HB_CENTRE) ? k : halfband_fir_pkg::HB_TAPS - 1 - k;
        case (d)
            0: c = 20'sh0034C;
            2: c = -20'sh0182D;
            4: c = 20'sh061F8;
            6: c = -20'sh13542;
            8: c = 20'sh4E830;
            9: c = 20'sh7FFFF;
            default: c = 20'sh00000;
        endcase
        if (hp && d != halfband_fir_pkg::HB_CENTRE) begin
            c = -c;
        end
        return c;
    endfunction : hbCoef

    // fir tap k, symmetric about the middle pair
    function automatic logic signed [20:0] firCoef(input int k);
        logic signed [20:0] c;
        int d;
        d = (k < halfband_fir_pkg::FIR_HALF) ? k : halfband_fir_pkg::FIR_TAPS - 1 - k;
        case (d)
            0: c = 21'sd383;
            1: c = 21'sd1431;
            2: c = 21'sd1950;
            3: c = 21'sd96;
            4: c = -21'sd2661;
            5: c = -21'sd1750;
            6: c = 21'sd2476;
            7: c = 21'sd2388;
            8: c = -21'sd3867;
            9: c = -21'sd5150;
            10: c = 21'sd3788;
            11: c = 21'sd7513;
            12: c = -21'sd4511;
            13: c = -21'sd11914;
            14: c = 21'sd3650;
            15: c = 21'sd16484;
            16: c = -21'sd2818;
            17: c = -21'sd23200;
            18: c = -21'sd48;
            19: c = 21'sd30748;
            20: c = 21'sd3976;
            21: c = -21'sd41019;
            22: c = -21'sd11147;
            23: c = 21'sd53608;
            24: c = 21'sd21818;
            25: c = -21'sd71611;
            26: c = -21'sd40300;
            27: c = 21'sd98830;
            28: c = 21'sd74264;
            29: c = -21'sd152696;
            30: c = -21'sd161248;
            31: c = 21'sd337056;
            default: c = 21'sd922060;
        endcase
        return c;
    endfunction : firCoef

    // cosine of step n out of eight, scaled by 2^14; sine is cosine two steps back
    function automatic logic signed [15:0] oscCos(input logic [2:0] n);
        logic signed [15:0] v;
        case (n)
            3'h0: v = halfband_fir_pkg::OSC_ONE;
            3'h1: v = halfband_fir_pkg::OSC_RT2;
            3'h2: v = 16'sh0000;
            3'h3: v = -halfband_fir_pkg::OSC_RT2;
            3'h4: v = -halfband_fir_pkg::OSC_ONE;
            3'h5: v = -halfband_fir_pkg::OSC_RT2;
            3'h6: v = 16'sh0000;
            default: v = halfband_fir_pkg::OSC_RT2;
        endcase
        return v;
    endfunction : oscCos

    // full-precision sum cut back to data width
    function automatic logic signed [DW-1:0] trunc(input logic signed [47:0] a, input int sh);
        logic signed [47:0] s;
        s = a >>> sh;
        return s[DW-1:0];
    endfunction : trunc

    // =========================================
    // declarations
    localparam int AW = halfband_fir_pkg::ACCW;
    localparam logic [2:0] OSC_SIN_LAG = 3'h2;
    logic syncMeta_q, syncSafe_q, syncPrev_q;
    logic syncArmed_q;
    logic syncEdge, syncAccept;
    logic phase_q;
    logic take_q;
    logic hbValid_q, hbOdd_q;
    logic signed [DW-1:0] hbLineI_q [halfband_fir_pkg::HB_TAPS];
    logic signed [DW-1:0] hbLineQ_q [halfband_fir_pkg::HB_TAPS];
    logic signed [DW-1:0] hbI_q, hbQ_q;
    logic signed [AW-1:0] hbAccI, hbAccQ;
    logic signed [DW-1:0] srcI, srcQ;
    logic signed [DW-1:0] firLineI_q [halfband_fir_pkg::FIR_TAPS];
    logic signed [DW-1:0] firLineQ_q [halfband_fir_pkg::FIR_TAPS];
    logic signed [AW-1:0] firAccI, firAccQ;
    logic firStep_q;
    logic s2Valid_q;
    logic signed [DW-1:0] s2I_q, s2Q_q;
    logic [2:0] oscIdx_q;
    logic signed [AW-1:0] mixAcc;
    halfband_fir_pkg::outSt_t outSt_q;
    logic signed [DW-1:0] heldQ_q;

    // =========================================
    // sync pin: two flops, then edge detect on the safe stage only
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            syncMeta_q <= 1'b0;
            syncSafe_q <= 1'b0;
            syncPrev_q <= 1'b0;
        end else begin
            syncMeta_q <= syncPin;
            syncSafe_q <= syncMeta_q;
            syncPrev_q <= syncSafe_q;
        end
    end

    assign syncEdge = syncSafe_q & ~syncPrev_q;
    // every-pulse mode, or one-shot mode consuming the arm
    assign syncAccept = syncEdge & syncEnable & (~syncFirstOnly | syncArmed_q);

    // a config write re-arms one-shot sync; the set wins over the consuming edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            syncArmed_q <= 1'b0;
        end else if (syncCfgWrite) begin
            syncArmed_q <= 1'b1;
        end else if (syncAccept) begin
            syncArmed_q <= 1'b0;
        end
    end

    // =========================================
    // input select: complex from tuning oscillator or real converter data
    assign srcI = tuneOscEnable ? tuneI : adcData;
    assign srcQ = tuneOscEnable ? tuneQ : '0;

    // decimation phase counter, restarted by an accepted sync
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            phase_q <= 1'b0;
            take_q <= 1'b0;
        end else if (syncAccept) begin
            phase_q <= 1'b0;
            take_q <= 1'b0;
        end else begin
            take_q <= inValid & (phase_q == hbDecPhase);
            if (inValid) begin
                phase_q <= ~phase_q;
            end
        end
    end

    // half-band delay lines, i and q side by side
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int k = 0; k < halfband_fir_pkg::HB_TAPS; k++) begin
                hbLineI_q[k] <= '0;
                hbLineQ_q[k] <= '0;
            end
        end else if (inValid) begin
            hbLineI_q[0] <= srcI;
            hbLineQ_q[0] <= srcQ;
            for (int k = 1; k < halfband_fir_pkg::HB_TAPS; k++) begin
                hbLineI_q[k] <= hbLineI_q[k-1];
                hbLineQ_q[k] <= hbLineQ_q[k-1];
            end
        end
    end

    // polyphase: only even taps and the centre tap carry weight
    always_comb begin
        hbAccI = AW'(hbLineI_q[halfband_fir_pkg::HB_CENTRE]) * AW'(hbCoef(halfband_fir_pkg::HB_CENTRE, hbHighPass));
        hbAccQ = AW'(hbLineQ_q[halfband_fir_pkg::HB_CENTRE]) * AW'(hbCoef(halfband_fir_pkg::HB_CENTRE, hbHighPass));
        for (int k = 0; k < halfband_fir_pkg::HB_TAPS; k += 2) begin
            hbAccI += AW'(hbLineI_q[k]) * AW'(hbCoef(k, hbHighPass));
            hbAccQ += AW'(hbLineQ_q[k]) * AW'(hbCoef(k, hbHighPass));
        end
    end

    // half-band output register; reversal negates every other output
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hbValid_q <= 1'b0;
            hbOdd_q <= 1'b0;
            hbI_q <= '0;
            hbQ_q <= '0;
        end else begin
            hbValid_q <= take_q;
            if (syncAccept) begin
                hbOdd_q <= 1'b0;
            end else if (take_q) begin
                hbOdd_q <= ~hbOdd_q;
            end
            if (take_q) begin
                hbI_q <= (hbSpecRev && hbOdd_q) ? -trunc(hbAccI, halfband_fir_pkg::HB_SHIFT)
                                               : trunc(hbAccI, halfband_fir_pkg::HB_SHIFT);
                hbQ_q <= (hbSpecRev && hbOdd_q) ? -trunc(hbAccQ, halfband_fir_pkg::HB_SHIFT)
                                               : trunc(hbAccQ, halfband_fir_pkg::HB_SHIFT);
            end
        end
    end

    // =========================================
    // fir delay lines advance once per half-band output
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int k = 0; k < halfband_fir_pkg::FIR_TAPS; k++) begin
                firLineI_q[k] <= '0;
                firLineQ_q[k] <= '0;
            end
        end else if (hbValid_q) begin
            firLineI_q[0] <= hbI_q;
            firLineQ_q[0] <= hbQ_q;
            for (int k = 1; k < halfband_fir_pkg::FIR_TAPS; k++) begin
                firLineI_q[k] <= firLineI_q[k-1];
                firLineQ_q[k] <= firLineQ_q[k-1];
            end
        end
    end

    // folded sum of products: pairs share a coefficient, halving the multipliers
    always_comb begin
        firAccI = '0;
        firAccQ = '0;
        for (int k = 0; k < halfband_fir_pkg::FIR_HALF; k++) begin
            firAccI += (AW'(firLineI_q[k]) + AW'(firLineI_q[halfband_fir_pkg::FIR_TAPS-1-k])) * AW'(firCoef(k));
            firAccQ += (AW'(firLineQ_q[k]) + AW'(firLineQ_q[halfband_fir_pkg::FIR_TAPS-1-k])) * AW'(firCoef(k));
        end
    end

    // stage-two register; bypass keeps the same latency so switching is glitch free
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            firStep_q <= 1'b0;
            s2Valid_q <= 1'b0;
            s2I_q <= '0;
            s2Q_q <= '0;
        end else begin
            firStep_q <= hbValid_q;
            s2Valid_q <= firStep_q;
            if (firStep_q) begin
                s2I_q <= firEnable ? trunc(firAccI, halfband_fir_pkg::FIR_SHIFT) : firLineI_q[0];
                s2Q_q <= firEnable ? trunc(firAccQ, halfband_fir_pkg::FIR_SHIFT) : firLineQ_q[0];
            end
        end
    end

    // =========================================
    // final oscillator: i*cos - q*sin, two steps per decimated sample
    always_comb begin
        mixAcc = AW'(s2I_q) * AW'(oscCos(oscIdx_q))
               - AW'(s2Q_q) * AW'(oscCos(oscIdx_q - OSC_SIN_LAG));
    end

    // oscillator index; realigned on sync so several devices share one output phase
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            oscIdx_q <= '0;
        end else if (syncAccept) begin
            oscIdx_q <= '0;
        end else if (s2Valid_q && finalOscEnable) begin
            oscIdx_q <= oscIdx_q + halfband_fir_pkg::OSC_ADVANCE;
        end
    end

    // output sequencer; a new sample cannot land on the q slot since outputs are two apart
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            outSt_q <= halfband_fir_pkg::OUT_FIRST;
            outData <= '0;
            outValid <= 1'b0;
            outIsQ <= 1'b0;
            heldQ_q <= '0;
        end else begin
            case (outSt_q)
                halfband_fir_pkg::OUT_FIRST: begin
                    outValid <= s2Valid_q;
                    outIsQ <= 1'b0;
                    if (s2Valid_q) begin
                        heldQ_q <= s2Q_q;
                        if (finalOscEnable) begin
                            outData <= trunc(mixAcc, halfband_fir_pkg::OSC_SHIFT);
                        end else begin
                            outData <= s2I_q;
                            if (tuneOscEnable) begin
                                outSt_q <= halfband_fir_pkg::OUT_SECOND;
                            end
                        end
                    end
                end
                halfband_fir_pkg::OUT_SECOND: begin
                    outData <= heldQ_q;
                    outValid <= 1'b1;
                    outIsQ <= 1'b1;
                    outSt_q <= halfband_fir_pkg::OUT_FIRST;
                end
                default: begin
                    outSt_q <= halfband_fir_pkg::OUT_FIRST;
                    outValid <= 1'b0;
                end
            endcase
        end
    end

    // =========================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    AST_HB_RATE: assert property (hbValid_q |=> !hbValid_q)
        else $error("half-band output faster than half rate");
    AST_HB_ALWAYS: assert property (take_q |=> hbValid_q)
        else $error("half-band output missing");
    AST_HB_COEF: assert property (hbCoef(9, 1'b0) == 20'sd524287 && hbCoef(18, 1'b0) == 20'sd844)
        else $error("half-band coefficient wrong");
    AST_HB_ODD: assert property (hbCoef(7, hbHighPass) == 20'sd0)
        else $error("odd half-band tap not zero");
    AST_HB_HP: assert property (hbCoef(8, 1'b1) == -hbCoef(8, 1'b0) && hbCoef(9, 1'b1) == hbCoef(9, 1'b0))
        else $error("high-pass sign pattern wrong");
    AST_FIR_COEF: assert property (firCoef(65) == 21'sd383 && firCoef(34) == 21'sd337056 && firCoef(32) == 21'sd922060)
        else $error("fir coefficient wrong");
    AST_FIR_RATE: assert property (hbValid_q |-> ##2 s2Valid_q)
        else $error("fir output does not follow each input");
    AST_PHASE: assert property ($past(syncAccept) && inValid && !syncAccept |-> ##2 (hbValid_q == !hbDecPhase))
        else $error("decimation phase after sync wrong");
    AST_SYNC_ONCE: assert property (syncAccept && syncFirstOnly && !syncCfgWrite |=> !syncArmed_q)
        else $error("one-shot sync not consumed");
    AST_SYNC_RESTART: assert property (syncAccept |=> phase_q == 1'b0 && !take_q)
        else $error("sync did not restart decimation");
    AST_OSC_STEP: assert property (s2Valid_q && finalOscEnable && !syncAccept |=> oscIdx_q == $past(oscIdx_q) + halfband_fir_pkg::OSC_ADVANCE)
        else $error("final oscillator step wrong");
    AST_IQ_PAIR: assert property (outSt_q == halfband_fir_pkg::OUT_SECOND |=> outValid && outIsQ)
        else $error("q sample missing after i");

    CV_SYNC: cover property (syncAccept);
    CV_FIR_OUT: cover property (s2Valid_q && firEnable);
    CV_REAL_OUT: cover property (outValid && finalOscEnable);
    CV_Q_OUT: cover property (outValid && outIsQ);
endmodule : halfband_fir_decimator

`default_nettype wire

/* File: halfband_fir_pkg.sv */
// constants for the half-band decimator, fir stage and final oscillator
// assumes a single sample clock and configuration bits driven as plain ports
package halfband_fir_pkg;
    // =========================================
    // half-band stage
    localparam int HB_TAPS = 19;
    localparam int HB_CENTRE = 9;
    localparam int HB_CW = 20;
    localparam int HB_SHIFT = 20;
    localparam int HB_DECIM = 2;
    // =========================================
    // fir stage
    localparam int FIR_TAPS = 66;
    localparam int FIR_HALF = 33;
    localparam int FIR_CW = 21;
    localparam int FIR_SHIFT = 21;
    // =========================================
    // final oscillator: eight steps per converter-rate cycle
    localparam int OSC_STEPS = 8;
    localparam int OSC_IW = 3;
    localparam int OSC_SHIFT = 14;
    localparam logic [2:0] OSC_ADVANCE = 3'h2;
    localparam logic signed [15:0] OSC_ONE = 16'sh4000;
    localparam logic signed [15:0] OSC_RT2 = 16'sh2D41;
    // =========================================
    // accumulator width and data-path limits
    localparam int ACCW = 48;
    localparam int DW_MIN = 8;
    localparam int DW_MAX = 24;
    // output sequencer for interleaved i/q
    typedef enum logic [0:0] {
        OUT_FIRST = 1'b0,
        OUT_SECOND = 1'b1
    } outSt_t;
endpackage : halfband_fir_pkg

/* File: output_sink_model.sv */
// output formatter stand-in: records every word that the decimator hands over
// assumes outputs are sampled on the rising edge of the shared sample clock
`timescale 1ns/100ps
`default_nettype none
module output_sink_model #(
    parameter int DW = 16
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic signed [DW-1:0] outData,
    input wire logic outValid,
    input wire logic outIsQ
);
    // =========================================
    // capture queues
    logic signed [DW-1:0] gotD[$];
    logic gotQ[$];
    // the formatter has no back-pressure, so every strobe is one word; reset empties the record
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gotD.delete();
            gotQ.delete();
        end else if (outValid === 1'b1) begin
            gotD.push_back(outData);
            gotQ.push_back(outIsQ);
        end
    end
endmodule : output_sink_model
`default_nettype wire

/* File: halfband_fir_decimator_tb_top.sv */
// self-checking bench: streams fixed patterns through the decimator and compares with a reference
// assumes halfband_fir_pkg, the decimator and output_sink_model are compiled before it
`timescale 1ns/100ps
`default_nettype none
module halfband_fir_decimator_tb_top;
    // =========================================
    // reference constants and stimulus
    localparam int N = 48;
    localparam int HE[5] = '{844, -6189, 25080, -79170, 321584};
    localparam int FC[33] = '{383, 1431, 1950, 96, -2661, -1750, 2476, 2388, -3867, -5150, 3788, 7513, -4511,
        -11914, 3650, 16484, -2818, -23200, -48, 30748, 3976, -41019, -11147, 53608, 21818, -71611, -40300,
        98830, 74264, -152696, -161248, 337056, 922060};
    localparam int COSE[4] = '{16384, 0, -16384, 0};
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic signed [15:0] adcData = 16'h0000, tuneI = 16'h0000, tuneQ = 16'h0000, outData;
    logic inValid = 1'b0, syncPin = 1'b0, hbHighPass = 1'b0, hbSpecRev = 1'b0, hbDecPhase = 1'b0;
    logic firEnable = 1'b0, syncEnable = 1'b0, syncFirstOnly = 1'b0, syncCfgWrite = 1'b0;
    logic tuneOscEnable = 1'b0, finalOscEnable = 1'b0, outValid, outIsQ;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    int qOn = 1;
    logic signed [15:0] expD[$];
    logic expQ[$];

    halfband_fir_decimator i_halfband_fir_decimator (
        .ref_clk(ref_clk), .nrst(nrst), .adcData(adcData), .tuneI(tuneI), .tuneQ(tuneQ),
        .inValid(inValid), .syncPin(syncPin), .hbHighPass(hbHighPass), .hbSpecRev(hbSpecRev),
        .hbDecPhase(hbDecPhase), .firEnable(firEnable), .syncEnable(syncEnable),
        .syncFirstOnly(syncFirstOnly), .syncCfgWrite(syncCfgWrite), .tuneOscEnable(tuneOscEnable),
        .finalOscEnable(finalOscEnable), .outData(outData), .outValid(outValid), .outIsQ(outIsQ));
    output_sink_model i_output_sink_model (.ref_clk(ref_clk), .nrst(nrst), .outData(outData),
        .outValid(outValid), .outIsQ(outIsQ));

    // =========================================
    // clock and watchdog
    always #10 ref_clk = ~ref_clk;
    // a hang is cut short well beyond the roughly 570 cycles that the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            end_of_test();
        end
    end

    // =========================================
    // helpers
    function automatic int pat(input int n, input int s);
        return ((n * s) % 61 - 30) * 250; // small amplitude keeps every stage clear of wrap
    endfunction : pat

    function automatic longint hbTap(input int k);
        longint c;
        c = (k == 9) ? 524287 : ((k % 2) ? 0 : HE[(k < 9 ? k : 18 - k) / 2]);
        return (hbHighPass && (k % 2 == 0)) ? -c : c;
    endfunction : hbTap

    task automatic check(input logic signed [15:0] seen, input logic signed [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t output word seen %0d expected %0d", $time, seen, exp);
        end
    endtask : check

    task automatic stream(input int a, input int b);
        for (int n = a; n < b; n++) begin
            adcData = 16'(pat(n, 37));
            tuneI = 16'(pat(n, 23));
            tuneQ = 16'(pat(n, 11) * qOn);
            inValid = 1'b1;
            @(negedge ref_clk);
        end
        inValid = 1'b0;
    endtask : stream

    task automatic pulse_sync();
        syncPin = 1'b1;
        repeat (2) @(negedge ref_clk);
        syncPin = 1'b0;
        repeat (1) @(negedge ref_clk);
    endtask : pulse_sync

    // reference: decimate, optional fir, optional fs/8 shift; r is the input index of a resync
    task automatic build(input int r);
        longint ai, aq;
        int m, base;
        logic signed [15:0] hi[$], hq[$];
        int hm[$];
        expD.delete();
        expQ.delete();
        m = 0;
        for (int n = 0; n < N; n++) begin
            if (n == r) m = 0;
            base = (n < r) ? n : n - r;
            if (base % 2 == hbDecPhase) begin
                ai = 0;
                aq = 0;
                for (int k = 0; k <= 18 && k <= n; k++) begin
                    ai += hbTap(k) * (tuneOscEnable ? pat(n - k, 23) : pat(n - k, 37));
                    aq += hbTap(k) * (tuneOscEnable ? pat(n - k, 11) * qOn : 0);
                end
                hi.push_back(16'((hbSpecRev && m % 2) ? -(ai >>> 20) : ai >>> 20));
                hq.push_back(16'((hbSpecRev && m % 2) ? -(aq >>> 20) : aq >>> 20));
                hm.push_back(m);
                m++;
            end
        end
        for (int j = 0; j < hi.size(); j++) begin
            ai = hi[j];
            aq = hq[j];
            if (firEnable) begin
                ai = 0;
                aq = 0;
                for (int k = 0; k < 66 && k <= j; k++) begin
                    ai += longint'(FC[k < 33 ? k : 65 - k]) * hi[j - k];
                    aq += longint'(FC[k < 33 ? k : 65 - k]) * hq[j - k];
                end
                ai = longint'(16'(ai >>> 21));
                aq = longint'(16'(aq >>> 21));
            end
            // q is held at zero whenever the shift is on, so only the cosine term is modelled
            if (finalOscEnable) ai = (ai * COSE[hm[j] % 4]) >>> 14;
            expD.push_back(16'(ai));
            expQ.push_back(1'b0);
            if (tuneOscEnable && !finalOscEnable) begin
                expD.push_back(16'(aq));
                expQ.push_back(1'b1);
            end
        end
    endtask : build

    // reset, arm and sync, stream, optionally resync at input r, then build the expectation
    task automatic run(input logic [5:0] cfg, input int r, input logic oneShot, input logic syncOn);
        {hbHighPass, hbSpecRev, hbDecPhase, firEnable, tuneOscEnable, finalOscEnable} = cfg;
        syncFirstOnly = oneShot;
        syncEnable = 1'b1;
        nrst = 1'b0;
        repeat (5) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        syncCfgWrite = 1'b1;
        @(negedge ref_clk);
        syncCfgWrite = 1'b0;
        pulse_sync();
        stream(0, r);
        syncEnable = syncOn;
        if (r < N) pulse_sync();
        stream(r, N);
        repeat (12) @(negedge ref_clk);
        build((syncOn && !oneShot) ? r : N);
    endtask : run

    task automatic compare(input string what);
        check(16'(i_output_sink_model.gotD.size()), 16'(expD.size()));
        for (int i = 0; i < expD.size() && i < i_output_sink_model.gotD.size(); i++) begin
            check(i_output_sink_model.gotD[i], expD[i]);
            check(16'(i_output_sink_model.gotQ[i]), 16'(expQ[i]));
        end
        $display("test %s done", what);
    endtask : compare

    // =========================================
    // scenarios
    task automatic test_lowpass_real();
        qOn = 1;
        run(6'h00, N, 1'b0, 1'b1);
        compare("low-pass real");
    endtask : test_lowpass_real

    task automatic test_highpass_late_phase();
        run(6'h28, N, 1'b0, 1'b1);
        compare("high-pass second phase");
    endtask : test_highpass_late_phase

    task automatic test_fir_interleaved();
        run(6'h02, N, 1'b0, 1'b1);
        compare("complex fir bypassed");
        run(6'h06, N, 1'b0, 1'b1);
        compare("complex fir inserted");
    endtask : test_fir_interleaved

    task automatic test_final_osc();
        qOn = 0;
        run(6'h07, N, 1'b0, 1'b1);
        compare("final shift real");
        qOn = 1;
    endtask : test_final_osc

    task automatic test_sync_modes();
        run(6'h18, 21, 1'b0, 1'b1);
        compare("resync every pulse");
        run(6'h18, 21, 1'b1, 1'b1);
        compare("resync first only");
        run(6'h18, 21, 1'b0, 1'b0);
        compare("resync disabled");
    endtask : test_sync_modes

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        test_lowpass_real();
        test_highpass_late_phase();
        test_fir_interleaved();
        test_final_osc();
        test_sync_modes();
        end_of_test();
    end
endmodule : halfband_fir_decimator_tb_top
`default_nettype wire
